// ===== bench/host_cpu_model.sv
// ==========================================================================
// host cpu side of the strobed register bus
module host_cpu_model (
    input wire logic ref_clk,
    output logic strobe_e,
    output logic read_sel,
    output logic reg_sel_lo,
    output logic reg_sel_hi,
    output logic [7:0] host_bus_in,
    input wire logic [7:0] host_bus_out,
    input wire logic host_bus_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle: unused select pair, strobe low
    initial begin
        strobe_e = 1'b0;
        read_sel = 1'b1;
        reg_sel_lo = 1'b1;
        reg_sel_hi = 1'b0;
        host_bus_in = 8'h5a;
    end
    // whole cycles, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    // setup, strobe high, take answer, hold after fall
    task automatic access(input logic rd, input logic lo, input logic hi, input logic [7:0] wd,
            input int high_cyc, output logic [7:0] rdv, output logic oe_seen);
        tick(1);
        read_sel = rd;
        reg_sel_lo = lo;
        reg_sel_hi = hi;
        host_bus_in = rd ? ~host_bus_in : wd;
        tick(3);
        strobe_e = 1'b1;
        tick(high_cyc);
        rdv = host_bus_out;
        oe_seen = host_bus_oe;
        strobe_e = 1'b0;
        tick(3);
        host_bus_in = ~host_bus_in; // released data, no pull
        tick(5);
    endtask
endmodule

// ===== bench/lcd_host_register_port_chk.sv
`include "lcd_port_cfg.svh"
// ==========================================================================
// port checker for the host register port
module lcd_host_register_port_chk #(
    parameter int OP_CYC = 20
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic strobe_e,
    input wire logic read_sel,
    input wire logic reg_sel_lo,
    input wire logic reg_sel_hi,
    input wire logic ext_driver_on,
    input wire logic [7:0] host_bus_out,
    input wire logic host_bus_oe,
    input wire logic busy_indicator,
    input wire logic [`LCD_CONTRAST_W-1:0] contrast_level,
    input wire logic [4:0] scan_digit,
    input wire logic ext_latch
);
    logic [4:0] low_cnt_r;
    logic [7:0] busy_cnt_r;
    logic [11:0] ext_cnt_r;
    logic ext_prev_r;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset || !clk_en);
    // strobe-low, busy and since-mode-change cycle counts, saturating
    always_ff @(posedge ref_clk) begin
        low_cnt_r <= (reset || strobe_e) ? 5'h00 : low_cnt_r + 5'(low_cnt_r != 5'h1f);
        busy_cnt_r <= (reset || !busy_indicator) ? 8'h00 : busy_cnt_r + 8'(busy_cnt_r != 8'hff);
        ext_cnt_r <= (reset || ext_driver_on != ext_prev_r) ? 12'h000
            : ext_cnt_r + 12'(ext_cnt_r != 12'hfff);
        ext_prev_r <= ext_driver_on;
    end
    a_reset_values: assert property ($fell(reset) |-> contrast_level == 5'h1f && !busy_indicator)
        else $error("contrast or busy not at reset value");
    a_write_quiet: assert property (!read_sel [*8] |-> !host_bus_oe)
        else $error("bus driven during a write");
    a_no_select: assert property ((reg_sel_lo && !reg_sel_hi) [*8] |-> !host_bus_oe)
        else $error("bus driven with unused select");
    // contrast changes by bus cycle only
    a_contrast_quiet: assert property (low_cnt_r >= 5'd12 |-> $stable(contrast_level))
        else $error("contrast changed without a bus cycle");
    a_busy_cause: assert property ($rose(busy_indicator) |-> low_cnt_r inside {[5'd2:5'd10]})
        else $error("busy rose without a recent access");
    a_busy_bound: assert property (busy_cnt_r <= 8'(OP_CYC + 16))
        else $error("busy held too long");
    a_status_busy: assert property ((strobe_e && read_sel && !reg_sel_lo && reg_sel_hi
        && $stable(busy_indicator)) [*8] |-> host_bus_oe && host_bus_out[7] == busy_indicator)
        else $error("status bit 7 differs from busy");
    a_contrast_read: assert property ((strobe_e && read_sel && !reg_sel_lo && !reg_sel_hi
        && $stable(contrast_level)) [*8] |-> host_bus_out == {3'h0, contrast_level})
        else $error("contrast read value wrong");
    a_scan_range: assert property (ext_cnt_r == 12'hfff
        |-> scan_digit <= (ext_driver_on ? 5'h1b : 5'h13))
        else $error("scan digit outside the display");
    // main scenarios reached
    c_busy: cover property ($rose(busy_indicator));
    c_latch: cover property ($rose(ext_latch));
    c_busy_read: cover property (host_bus_oe && busy_indicator);
endmodule
bind lcd_host_register_port lcd_host_register_port_chk #(.OP_CYC(OP_CYC)) u_chk (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .strobe_e(strobe_e),
    .read_sel(read_sel), .reg_sel_lo(reg_sel_lo), .reg_sel_hi(reg_sel_hi),
    .ext_driver_on(ext_driver_on), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
    .busy_indicator(busy_indicator), .contrast_level(contrast_level),
    .scan_digit(scan_digit), .ext_latch(ext_latch));

// ===== bench/test_lcd_host_register_port.sv
module test_lcd_host_register_port
    import lcd_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, reset, clk_en, strobe_e, read_sel, reg_sel_lo, reg_sel_hi, step_up;
    logic ext_driver_on, host_bus_oe, busy_indicator, ext_data, ext_shift_clk, ext_latch, ov;
    logic [7:0] host_bus_in, host_bus_out, scan_char, rv, d, gv;
    logic [4:0] contrast_level, scan_digit, mx;
    logic [6:0] a;
    logic [63:0] ser, fr;
    logic [7:0] mem [0:79];
    int err_count = 0;
    int check_count = 0;
    int bits = 0;
    int cycles = 0;
    // ======================================================================
    // design, host model, clock and watchdog
    lcd_host_register_port #(.OP_CYC(60), .CP_HALF_CYC(2)) u_dut (.ref_clk(ref_clk),
        .reset(reset), .clk_en(clk_en), .strobe_e(strobe_e), .read_sel(read_sel),
        .reg_sel_lo(reg_sel_lo), .reg_sel_hi(reg_sel_hi), .host_bus_in(host_bus_in),
        .step_up(step_up), .ext_driver_on(ext_driver_on), .host_bus_out(host_bus_out),
        .host_bus_oe(host_bus_oe), .busy_indicator(busy_indicator),
        .contrast_level(contrast_level), .scan_digit(scan_digit), .scan_char(scan_char),
        .ext_data(ext_data), .ext_shift_clk(ext_shift_clk), .ext_latch(ext_latch));
    host_cpu_model u_host (.ref_clk(ref_clk), .strobe_e(strobe_e), .read_sel(read_sel),
        .reg_sel_lo(reg_sel_lo), .reg_sel_hi(reg_sel_hi), .host_bus_in(host_bus_in),
        .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe));
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            $display("timeout after %0d cycles", cycles);
            complete_run();
        end
    end
    // extension link bits, taken at the shift clock rise
    always @(posedge ext_shift_clk) begin
        ser = {ser[62:0], ext_data};
        bits++;
    end
    // ======================================================================
    // comparison, verdict and bus tasks
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic acc(input logic rd, input logic lo, input logic hi, input logic [7:0] wd);
        u_host.access(rd, lo, hi, wd, $urandom_range(12, 7), rv, ov);
    endtask
    // poll status until busy clears; leaves the pointer in rv
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            acc(1'b1, 1'b0, 1'b1, 8'h00);
            n++;
        end while (rv[7] !== 1'b0 && n < 10);
        check("busy_clear", rv[7], 1'b0);
    endtask
    task automatic set_addr(input logic [7:0] code);
        acc(1'b0, 1'b0, 1'b1, code);
        wait_idle();
    endtask
    task automatic wr_data(input logic [7:0] v);
        acc(1'b0, 1'b1, 1'b1, v);
        wait_idle();
    endtask
    task automatic rd_data(output logic [7:0] v);
        acc(1'b1, 1'b1, 1'b1, 8'h00);
        v = rv;
        wait_idle();
    endtask
    // ======================================================================
    // main sequence
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        clk_en = 1'b1;
        step_up = 1'b1;
        ext_driver_on = 1'b0;
        void'($urandom(51175));
        repeat (20) @(posedge ref_clk);
        #5;
        reset = 1'b0;
        // contrast reset value, extremes, random, then unused select
        acc(1'b1, 1'b0, 1'b0, 8'h00);
        check("contrast_reset", rv, 8'h1f);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            acc(1'b0, 1'b0, 1'b0, d);
            acc(1'b1, 1'b0, 1'b0, 8'h00);
            check("contrast_read", {ov, rv}, {1'b1, 3'h0, d[4:0]});
            check("contrast_level", contrast_level, d[4:0]);
        end
        acc(1'b0, 1'b1, 1'b0, 8'h07);
        acc(1'b1, 1'b1, 1'b0, 8'h00);
        check("unused_oe", ov, 1'b0);
        check("unused_write", contrast_level, d[4:0]);
        $display("test contrast done");
        // character ram: address set, writes, pointer, read back
        for (int r = 0; r < 3; r++) begin
            a = 7'($urandom_range(70, 1));
            set_addr({1'b1, a});
            check("status_after_set", rv, {1'b0, a});
            for (int k = 0; k < 4; k++) begin
                mem[a + k] = 8'($urandom);
                wr_data(mem[a + k]);
            end
            check("ptr_step_up", rv, {1'b0, a + 7'd4});
            set_addr({1'b1, a});
            for (int k = 0; k < 4; k++) begin
                rd_data(d);
                check("ram_read", d, mem[a + k]);
            end
        end
        step_up = 1'b0;
        set_addr(8'h80);
        wr_data(8'h3c);
        check("ptr_wrap_down", rv, 8'h4f);
        step_up = 1'b1;
        $display("test char ram done");
        // glyph ram address set, write and read back
        a = 7'($urandom_range(62, 0));
        d = 8'($urandom);
        set_addr({2'b01, a[5:0]});
        wr_data(d);
        check("glyph_ptr", rv[5:0], a[5:0] + 6'd1);
        set_addr({2'b01, a[5:0]});
        rd_data(gv);
        check("glyph_read", gv, d);
        $display("test glyph ram done");
        // a write arriving while busy is dropped
        a = 7'($urandom_range(70, 1));
        set_addr({1'b1, a});
        mem[a] = 8'($urandom);
        acc(1'b0, 1'b1, 1'b1, mem[a]);
        acc(1'b1, 1'b0, 1'b1, 8'h00);
        check("busy_seen", {ov, rv[7]}, 2'b11);
        acc(1'b0, 1'b1, 1'b1, ~mem[a]);
        wait_idle();
        check("ptr_after_drop", rv, {1'b0, a + 7'd1});
        set_addr({1'b1, a});
        rd_data(d);
        check("ram_after_drop", d, mem[a]);
        $display("test busy drop done");
        // refresh scan alone, then with the extension driver
        set_addr(8'h80);
        for (int k = 0; k < 28; k++) begin
            mem[k] = 8'($urandom);
            wr_data(mem[k]);
            fr = {fr[55:0], mem[k]};
        end
        mx = 5'h00;
        repeat (200) begin
            @(posedge ref_clk);
            #5;
            if (scan_digit > mx) mx = scan_digit;
            if (scan_digit == 5'h03) check("scan_char", scan_char, mem[3]);
        end
        check("scan_last", mx, 5'h13);
        ext_driver_on = 1'b1;
        @(posedge ext_latch);
        bits = 0;
        @(posedge ext_latch);
        check("ext_bit_count", bits, 64);
        check("ext_frame", ser, fr);
        $display("test scan done");
        complete_run();
    end
endmodule

// ===== rtl/lcd_host_register_port.sv
`include "lcd_port_cfg.svh"

module lcd_host_register_port
    import lcd_port_pkg::*;
#(
    parameter int DD_DEPTH = `LCD_DD_DEPTH,
    parameter int CG_DEPTH = `LCD_CG_DEPTH,
    parameter int OP_CYC = `LCD_OP_CYC,
    parameter int CP_HALF_CYC = `LCD_CP_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic strobe_e,
    input wire logic read_sel,
    input wire logic reg_sel_lo,
    input wire logic reg_sel_hi,
    input wire logic [7:0] host_bus_in,
    input wire logic step_up,
    input wire logic ext_driver_on,
    output logic [7:0] host_bus_out,
    output logic host_bus_oe,
    output logic busy_indicator,
    output logic [`LCD_CONTRAST_W-1:0] contrast_level,
    output logic [4:0] scan_digit,
    output logic [7:0] scan_char,
    output logic ext_data,
    output logic ext_shift_clk,
    output logic ext_latch
);

    localparam int PW = `LCD_PTR_W;
    localparam int TW = $clog2(2 * CP_HALF_CYC + 1);
    localparam int HW = $clog2(OP_CYC + 1);

    // ======================================================================
    // pin capture
    bus_sample_type pins_raw;
    bus_sample_type smp;
    bus_sample_type held_r;
    logic strobe_prev_r;
    logic fall;

    assign pins_raw = '{strobe: strobe_e, rd: read_sel, sel_lo: reg_sel_lo,
                        sel_hi: reg_sel_hi, data: host_bus_in};

    pin_sync #(
        .W($bits(bus_sample_type))
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .pin_in(pins_raw),
        .pin_out(smp)
    );

    // hold the pins seen while strobe high, so late pin changes do not leak in
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            held_r <= '0;
            strobe_prev_r <= 1'b0;
        end else if (clk_en) begin
            strobe_prev_r <= smp.strobe;
            if (smp.strobe) begin
                held_r <= smp;
            end
        end
    end

    assign fall = strobe_prev_r & ~smp.strobe;

    function automatic reg_sel_type decode_sel(input logic lo, input logic hi);
        if (lo && hi) begin
            decode_sel = SEL_DATA;
        end else if (!lo && hi) begin
            decode_sel = SEL_CMD;
        end else if (!lo && !hi) begin
            decode_sel = SEL_CONTRAST;
        end else begin
            decode_sel = SEL_NONE;
        end
    endfunction

    reg_sel_type cap_sel;
    reg_sel_type live_sel;
    assign cap_sel = decode_sel(held_r.sel_lo, held_r.sel_hi);
    assign live_sel = decode_sel(smp.sel_lo, smp.sel_hi);

    // ======================================================================
    // rams and shared state
    logic [7:0] dd_mem [DD_DEPTH];
    logic [7:0] cg_mem [CG_DEPTH];
    ctl_state_type ctl_r;
    ser_state_type ser_r;
    logic phase_r;
    logic [PW-1:0] ptr_r;
    logic cg_sel_r;
    logic op_write_r;
    logic [7:0] wdata_r;
    logic [7:0] data_reg_r;
    logic [HW-1:0] hold_cnt_r;
    logic [PW-1:0] scan_addr_r;
    logic busy;
    logic host_slot;
    logic [PW-1:0] ptr_step;
    logic [PW-1:0] last_addr;

    // alternate slots: even for refresh, odd for host traffic
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_r <= 1'b0;
        end else if (clk_en) begin
            phase_r <= ~phase_r;
        end
    end

    assign host_slot = phase_r;
    assign busy = (ctl_r != CT_IDLE);

    // step by one in the configured direction, wrapped to the target ram
    always_comb begin
        ptr_step = step_up ? ptr_r + 7'h01 : ptr_r - 7'h01;
        if (cg_sel_r) begin
            ptr_step[PW-1] = 1'b0;
        end else if (step_up && ptr_r == PW'(DD_DEPTH - 1)) begin
            ptr_step = '0;
        end else if (!step_up && ptr_r == '0) begin
            ptr_step = PW'(DD_DEPTH - 1);
        end
    end

    // one code per character ram location
    function automatic logic [7:0] ram_read(input logic cg, input logic [PW-1:0] a,
                                            input logic [7:0] dd_word,
                                            input logic [7:0] cg_word);
        if (cg) begin
            ram_read = (int'(a) < CG_DEPTH) ? cg_word : 8'h00;
        end else begin
            ram_read = (int'(a) < DD_DEPTH) ? dd_word : 8'h00;
        end
    endfunction

    logic [7:0] host_word;
    logic [7:0] scan_word;
    assign host_word = ram_read(cg_sel_r, ptr_r,
                                dd_mem[int'(ptr_r) % DD_DEPTH],
                                cg_mem[int'(ptr_r) % CG_DEPTH]);
    assign scan_word = ram_read(1'b0, scan_addr_r,
                                dd_mem[int'(scan_addr_r) % DD_DEPTH], 8'h00);

    // ======================================================================
    // contrast register
    // written on any write cycle with both selects low, no busy gating unlike the command and data registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            contrast_level <= `LCD_CONTRAST_RST;
        end else if (clk_en && fall && !held_r.rd && cap_sel == SEL_CONTRAST) begin
            contrast_level <= held_r.data[`LCD_CONTRAST_W-1:0];
        end
    end

    // ======================================================================
    // host operation sequencer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctl_r <= CT_IDLE;
            busy_indicator <= 1'b0;
            ptr_r <= '0;
            cg_sel_r <= 1'b0;
            op_write_r <= 1'b0;
            wdata_r <= 8'h00;
            data_reg_r <= 8'h00;
            hold_cnt_r <= '0;
        end else if (clk_en) begin
            unique case (ctl_r)
                CT_IDLE: begin
                    // only taken while idle, so busy discards it
                    if (fall && cap_sel == SEL_CMD && !held_r.rd) begin
                        // choose target ram then load the pointer
                        if (held_r.data[`LCD_CMD_DD_BIT]) begin
                            cg_sel_r <= 1'b0;
                            ptr_r <= held_r.data[PW-1:0];
                            ctl_r <= CT_FETCH;
                        end else if (held_r.data[`LCD_CMD_CG_HI:`LCD_CMD_CG_LO]
                                     == `LCD_CMD_CG_CODE) begin
                            cg_sel_r <= 1'b1;
                            ptr_r <= {1'b0, held_r.data[PW-2:0]};
                            ctl_r <= CT_FETCH;
                        end else begin
                            ctl_r <= CT_HOLD;
                        end
                        busy_indicator <= 1'b1;
                    end else if (fall && cap_sel == SEL_DATA) begin
                        // data write goes to ram, read steps then prefetches
                        op_write_r <= ~held_r.rd;
                        wdata_r <= held_r.data;
                        ctl_r <= CT_RAM;
                        busy_indicator <= 1'b1;
                    end
                end
                CT_RAM: begin
                    if (host_slot) begin
                        ptr_r <= ptr_step;
                        ctl_r <= op_write_r ? CT_HOLD : CT_FETCH;
                    end
                end
                CT_FETCH: begin
                    if (host_slot) begin
                        data_reg_r <= host_word;
                        ctl_r <= CT_HOLD;
                    end
                end
                CT_HOLD: begin
                    // busy covers the whole operation time
                    if (hold_cnt_r == HW'(OP_CYC - 1)) begin
                        hold_cnt_r <= '0;
                        ctl_r <= CT_IDLE;
                        busy_indicator <= 1'b0;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // ram write in the host slot only
    always_ff @(posedge ref_clk) begin
        if (clk_en && ctl_r == CT_RAM && host_slot && op_write_r) begin
            if (cg_sel_r && int'(ptr_r) < CG_DEPTH) begin
                cg_mem[int'(ptr_r) % CG_DEPTH] <= wdata_r;
            end else if (!cg_sel_r && int'(ptr_r) < DD_DEPTH) begin
                dd_mem[int'(ptr_r) % DD_DEPTH] <= wdata_r;
            end
        end
    end

    // ======================================================================
    // host read data
    // drive while strobe high with read selected and a select pair other than the unused one
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_bus_oe <= 1'b0;
            host_bus_out <= 8'h00;
        end else if (clk_en) begin
            host_bus_oe <= smp.strobe && smp.rd && live_sel != SEL_NONE;
            unique case (live_sel)
                // busy on bit 7, pointer below it
                SEL_CMD: host_bus_out <= {busy_indicator, ptr_r};
                SEL_DATA: host_bus_out <= data_reg_r;
                SEL_CONTRAST: host_bus_out <= {3'h0, contrast_level};
                SEL_NONE: host_bus_out <= 8'h00;
            endcase
        end
    end

    // ======================================================================
    // refresh scan and extension driver transfer
    logic [TW-1:0] tmr_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;

    // last scanned address depends on the extension driver
    assign last_addr = ext_driver_on ? `LCD_LAST_ADDR_EXT : `LCD_LAST_ADDR_BASE;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ser_r <= SR_FETCH;
            scan_addr_r <= '0;
            scan_digit <= 5'h00;
            scan_char <= 8'h00;
            ext_data <= 1'b0;
            ext_shift_clk <= 1'b0;
            ext_latch <= 1'b0;
            tmr_r <= '0;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
        end else if (clk_en) begin
            unique case (ser_r)
                SR_FETCH: begin
                    // refresh reads only in its own slot
                    if (!host_slot) begin
                        scan_char <= scan_word;
                        scan_digit <= scan_addr_r[4:0];
                        if (ext_driver_on && scan_addr_r >= `LCD_EXT_FIRST_ADDR) begin
                            // digits twenty and up go out serially
                            shift_r <= {scan_word[6:0], 1'b0};
                            ext_data <= scan_word[7];
                            bit_cnt_r <= 3'h0;
                            tmr_r <= '0;
                            ser_r <= SR_LOW;
                        end else if (scan_addr_r >= last_addr) begin
                            scan_addr_r <= '0;
                        end else begin
                            scan_addr_r <= scan_addr_r + 7'h01;
                        end
                    end
                end
                SR_LOW: begin
                    if (tmr_r == TW'(CP_HALF_CYC - 1)) begin
                        tmr_r <= '0;
                        ext_shift_clk <= 1'b1;
                        ser_r <= SR_HIGH;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
                SR_HIGH: begin
                    if (tmr_r == TW'(CP_HALF_CYC - 1)) begin
                        tmr_r <= '0;
                        ext_shift_clk <= 1'b0;
                        if (bit_cnt_r == 3'(`LCD_EXT_BITS - 1)) begin
                            ser_r <= (scan_addr_r >= last_addr) ? SR_LATCH : SR_FETCH;
                            scan_addr_r <= scan_addr_r + 7'h01;
                        end else begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            ext_data <= shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                            ser_r <= SR_LOW;
                        end
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
                SR_LATCH: begin
                    // latch after a setup half period, high for one half
                    ext_latch <= (tmr_r >= TW'(CP_HALF_CYC - 1))
                                 && (tmr_r != TW'(2 * CP_HALF_CYC - 1));
                    if (tmr_r == TW'(2 * CP_HALF_CYC - 1)) begin
                        tmr_r <= '0;
                        scan_addr_r <= '0;
                        ser_r <= SR_FETCH;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
            endcase
        end
    end

endmodule

// ===== rtl/lcd_port_cfg.svh
`ifndef LCD_PORT_CFG_SVH
`define LCD_PORT_CFG_SVH

// ==========================================================================
// contrast register
`define LCD_CONTRAST_W 5
`define LCD_CONTRAST_RST 5'h1f

// ==========================================================================
// command field layout
`define LCD_CMD_DD_BIT 7
`define LCD_CMD_CG_HI 7
`define LCD_CMD_CG_LO 6
`define LCD_CMD_CG_CODE 2'h1
`define LCD_STATUS_BUSY_BIT 7

// ==========================================================================
// ram sizes and display address map
`define LCD_PTR_W 7
`define LCD_DD_DEPTH 80
`define LCD_CG_DEPTH 64
`define LCD_LAST_ADDR_BASE 7'h13
`define LCD_LAST_ADDR_EXT 7'h1b
`define LCD_EXT_FIRST_ADDR 7'h14
`define LCD_EXT_BITS 8

// ==========================================================================
// timing, in ns and in cycles of the 20 MHz reference clock
`define LCD_CLK_PERIOD_NS 50
`define LCD_CP_HALF_NS 800
`define LCD_CP_HALF_CYC ((`LCD_CP_HALF_NS + `LCD_CLK_PERIOD_NS - 1) / `LCD_CLK_PERIOD_NS)
`define LCD_OP_TIME_NS 1000
`define LCD_OP_CYC ((`LCD_OP_TIME_NS + `LCD_CLK_PERIOD_NS - 1) / `LCD_CLK_PERIOD_NS)

`endif

// ===== rtl/lcd_port_pkg.sv
package lcd_port_pkg;

    // ======================================================================
    // sampled host pins, kept together through the synchroniser
    typedef struct packed {
        logic strobe;
        logic rd;
        logic sel_lo;
        logic sel_hi;
        logic [7:0] data;
    } bus_sample_type;

    // ======================================================================
    // register selected by the two select pins
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_DATA = 3'h1,
        SEL_CMD = 3'h2,
        SEL_CONTRAST = 3'h4
    } reg_sel_type;

    // ======================================================================
    // host operation sequencer
    typedef enum logic [3:0] {
        CT_IDLE = 4'h1,
        CT_RAM = 4'h2,
        CT_FETCH = 4'h4,
        CT_HOLD = 4'h8
    } ctl_state_type;

    // ======================================================================
    // refresh scan and extension driver transfer
    typedef enum logic [3:0] {
        SR_FETCH = 4'h1,
        SR_LOW = 4'h2,
        SR_HIGH = 4'h4,
        SR_LATCH = 4'h8
    } ser_state_type;

endpackage

// ===== rtl/pin_sync.sv
// three-stage pin synchroniser; output follows once stages two and three agree
module pin_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // shift chain, first stage read only by the second
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else if (clk_en) begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // per-bit filter: take a new level only when two stages agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_out <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    pin_out[i] <= s3_r[i];
                end
            end
        end
    end

endmodule
